// ---- two_wire_pkg.sv ----
// constants, codes and types of the two-wire master-transmit block
package two_wire_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  // control register fields
  localparam int FLAG_BIT = 7;
  localparam int ACKEN_BIT = 6;
  localparam int START_BIT = 5;
  localparam int STOP_BIT = 4;
  localparam int WCOL_BIT = 3;
  localparam int EN_BIT = 2;
  // interrupt fields
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_WCOL = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] PRESC_RST = 2'h0;
  // status codes, prescaler bits masked to zero
  localparam logic [7:0] CODE_IDLE = 8'hF8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RESTART = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_LOST = 8'h38;
  localparam logic [7:0] CODE_RADDR_ACK = 8'h40;
  localparam logic [7:0] CODE_RADDR_NACK = 8'h48;
  localparam logic [7:0] CODE_MASK = 8'hF8;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_TIME_NS = 10000;
  localparam int QTR_CYCLES = BIT_TIME_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [7:0] {
    S_IDLE     = 8'h01,
    S_WAITFREE = 8'h02,
    S_START    = 8'h04,
    S_RESTART  = 8'h08,
    S_BITS     = 8'h10,
    S_ACK      = 8'h20,
    S_STOP     = 8'h40,
    S_HOLD     = 8'h80
  } state_t;
endpackage : two_wire_pkg

// ---- two_flop_sync.sv ----
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module two_flop_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : two_flop_sync

// ---- two_wire_master.sv ----
// two-wire master transmitter with status sequencing and AXI4-Lite registers
`timescale 1ns/1ps
module two_wire_master (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic [two_wire_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [two_wire_pkg::ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  input  wire logic                         sclIn,
  output logic                              sclOut,
  output logic                              sclOeN,
  input  wire logic                         sdaIn,
  output logic                              sdaOut,
  output logic                              sdaOeN,
  output logic                              irq
);
  import two_wire_pkg::*;

  state_t             state;
  logic [ADDR_W-1:0]  wAddr;
  logic [7:0]         wData;
  logic               wLane;
  logic               doWrite;
  logic               ctrlWr;
  logic               dataWr;
  logic               statWr;
  logic               irqStatWr;
  logic               irqMaskWr;
  logic [31:0]        readMux;
  logic               readOk;
  logic               flag;
  logic               ackEn;
  logic               startReq;
  logic               stopReq;
  logic               wcol;
  logic               enable;
  logic [7:0]         dataReg;
  logic [1:0]         prescaler;
  logic [7:0]         statusCode;
  logic [IRQ_W-1:0]   irqStat;
  logic [IRQ_W-1:0]   irqMask;
  logic [IRQ_W-1:0]   irqSet;
  logic [7:0]         qtrCnt;
  logic               tick;
  logic [1:0]         phase;
  logic               step;
  logic               sclSync;
  logic               sdaSync;
  logic               sclPrev;
  logic               sdaPrev;
  logic               busBusy;
  logic [7:0]         shift;
  logic [2:0]         bitCnt;
  logic               addrPhase;
  logic               readAddr;
  logic               repeated;
  logic               ackLow;
  logic [7:0]         ackCode;
  logic               goCmd;
  logic               cmdSta;
  logic               cmdSto;
  logic               finStart;
  logic               finAck;
  logic               finStop;
  logic               lost;
  logic               setFlag;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  two_flop_sync sclSyncInst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (sclIn),
    .dout     (sclSync)
  );

  two_flop_sync sdaSyncInst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (sdaIn),
    .dout     (sdaSync)
  );

  // axi write channels, address and data taken in either order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wAddr   <= '0;
      wData   <= 8'h00;
      wLane   <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        wAddr   <= awaddr;
      end
      else if (bvalid && bready)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        wData  <= wdata[7:0];
        wLane  <= wstrb[0];
      end
      else if (bvalid && bready)
        wready <= 1'b1;
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= isMapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == DATA_OFS) ||
               (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction : isMapped

  assign doWrite   = !awready && !wready && !bvalid;
  assign ctrlWr    = doWrite && wLane && (wAddr == CTRL_OFS);
  assign statWr    = doWrite && wLane && (wAddr == STAT_OFS);
  assign dataWr    = doWrite && wLane && (wAddr == DATA_OFS);
  assign irqStatWr = doWrite && wLane && (wAddr == IRQ_STAT_OFS);
  assign irqMaskWr = doWrite && wLane && (wAddr == IRQ_MASK_OFS);

  // read decode
  always_comb
  begin
    readMux = 32'h0000_0000;
    readOk  = 1'b1;
    if (araddr == CTRL_OFS)
      readMux[7:0] = {flag, ackEn, startReq, stopReq, wcol, enable, 2'h0};
    else if (araddr == STAT_OFS)
      readMux[7:0] = (statusCode & CODE_MASK) | {6'h00, prescaler};
    else if (araddr == DATA_OFS)
      readMux[7:0] = dataReg;
    else if (araddr == IRQ_STAT_OFS)
      readMux[IRQ_W-1:0] = irqStat;
    else if (araddr == IRQ_MASK_OFS)
      readMux[IRQ_W-1:0] = irqMask;
    else
      readOk = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= readMux;
      rresp   <= readOk ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // software command decode
  assign cmdSta  = wData[START_BIT];
  assign cmdSto  = wData[STOP_BIT];
  assign goCmd   = ctrlWr && wData[FLAG_BIT] && wData[EN_BIT];

  // completion flag, hardware set wins over software clear
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else if (setFlag)
      flag <= 1'b1;
    else if (ctrlWr && wData[FLAG_BIT])
      flag <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ackEn    <= 1'b0;
      startReq <= 1'b0;
      stopReq  <= 1'b0;
      enable   <= 1'b0;
    end
    else if (ctrlWr)
    begin
      ackEn    <= wData[ACKEN_BIT];
      startReq <= wData[START_BIT];
      stopReq  <= wData[STOP_BIT];
      enable   <= wData[EN_BIT];
    end
    else if (finStop)
      stopReq <= 1'b0;
  end

  // data register guarded by the flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dataReg <= DATA_RST;
      wcol    <= 1'b0;
    end
    else if (dataWr && flag)
    begin
      dataReg <= wData;
      wcol    <= 1'b0;
    end
    else if (dataWr)
      wcol <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prescaler <= PRESC_RST;
    else if (statWr)
      prescaler <= wData[1:0];
  end

  // interrupts
  assign irqSet = {dataWr && !flag, lost, setFlag};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irqStat <= IRQ_RST;
      irqMask <= IRQ_RST;
      irq     <= 1'b0;
    end
    else
    begin
      irqStat <= (irqStat & ~(irqStatWr ? wData[IRQ_W-1:0] : IRQ_RST)) | irqSet;
      if (irqMaskWr)
        irqMask <= wData[IRQ_W-1:0];
      irq <= |(irqStat & irqMask);
    end
  end

  // quarter-bit enable
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || qtrCnt == QTR_LAST)
      qtrCnt <= 8'h00;
    else
      qtrCnt <= qtrCnt + 8'h01;
    tick <= rst_n && (qtrCnt == QTR_LAST);
  end

  // bus free detection
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      busBusy <= 1'b0;
    end
    else
    begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
      if (sclSync && sclPrev && sdaPrev && !sdaSync)
        busBusy <= 1'b1;
      else if (sclSync && sclPrev && !sdaPrev && sdaSync)
        busBusy <= 1'b0;
    end
  end

  // quarter phase, held while the clock line is stretched low
  assign step = tick && !(phase == 2'h2 && !sclSync);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !enable || state == S_IDLE || state == S_WAITFREE || state == S_HOLD)
      phase <= 2'h0;
    else if (step)
      phase <= phase + 2'h1;
  end

  assign finStart = (state == S_START) && step && (phase == 2'h3);
  assign finAck   = (state == S_ACK) && step && (phase == 2'h3);
  assign finStop  = (state == S_STOP) && step && (phase == 2'h3);
  assign lost     = (state == S_BITS) && step && (phase == 2'h2) && shift[7] && !sdaSync;
  assign setFlag  = finStart || finAck || lost;

  always_comb
  begin
    if (addrPhase && readAddr)
      ackCode = ackLow ? CODE_RADDR_ACK : CODE_RADDR_NACK;
    else if (addrPhase)
      ackCode = ackLow ? CODE_ADDR_ACK : CODE_ADDR_NACK;
    else
      ackCode = ackLow ? CODE_DATA_ACK : CODE_DATA_NACK;
  end

  // bus sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state      <= S_IDLE;
      sclOeN     <= 1'b1;
      sdaOeN     <= 1'b1;
      statusCode <= CODE_IDLE;
      shift      <= 8'h00;
      bitCnt     <= 3'h0;
      addrPhase  <= 1'b0;
      readAddr   <= 1'b0;
      repeated   <= 1'b0;
      ackLow     <= 1'b0;
    end
    else if (!enable && !goCmd)
    begin
      state  <= S_IDLE;
      sclOeN <= 1'b1;
      sdaOeN <= 1'b1;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (goCmd && cmdSta)
            state <= S_WAITFREE;
        S_WAITFREE:
          if (!busBusy && tick)
          begin
            state    <= S_START;
            repeated <= 1'b0;
          end
        S_START:
          if (step && phase == 2'h1)
            sdaOeN <= 1'b0;
          else if (step && phase == 2'h3)
          begin
            sclOeN     <= 1'b0;
            statusCode <= repeated ? CODE_RESTART : CODE_START;
            addrPhase  <= 1'b1;
            state      <= S_HOLD;
          end
        S_RESTART:
          if (step && phase == 2'h0)
            sdaOeN <= 1'b1;
          else if (step && phase == 2'h1)
            sclOeN <= 1'b1;
          else if (step && phase == 2'h3)
          begin
            state    <= S_START;
            repeated <= 1'b1;
          end
        S_BITS:
          if (lost)
          begin
            sclOeN     <= 1'b1;
            sdaOeN     <= 1'b1;
            statusCode <= CODE_LOST;
            state      <= S_HOLD;
          end
          else if (step && phase == 2'h0)
            sdaOeN <= shift[7];
          else if (step && phase == 2'h1)
            sclOeN <= 1'b1;
          else if (step && phase == 2'h3)
          begin
            sclOeN <= 1'b0;
            shift  <= {shift[6:0], 1'b0};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == BIT_LAST)
              state <= S_ACK;
          end
        S_ACK:
          if (step && phase == 2'h0)
            sdaOeN <= 1'b1;
          else if (step && phase == 2'h1)
            sclOeN <= 1'b1;
          else if (step && phase == 2'h2)
            ackLow <= !sdaSync;
          else if (step && phase == 2'h3)
          begin
            sclOeN     <= 1'b0;
            statusCode <= ackCode;
            addrPhase  <= 1'b0;
            state      <= S_HOLD;
          end
        S_STOP:
          if (step && phase == 2'h0)
            sdaOeN <= 1'b0;
          else if (step && phase == 2'h1)
            sclOeN <= 1'b1;
          else if (step && phase == 2'h3)
          begin
            sdaOeN <= 1'b1;
            state  <= startReq ? S_WAITFREE : S_IDLE;
          end
        S_HOLD:
          if (goCmd && flag)
          begin
            if (statusCode == CODE_LOST)
              state <= cmdSta ? S_WAITFREE : S_IDLE;
            else if (cmdSto)
              state <= S_STOP;
            else if (cmdSta)
              state <= S_RESTART;
            else
            begin
              state  <= S_BITS;
              shift  <= dataReg;
              bitCnt <= 3'h0;
              if (addrPhase)
                readAddr <= dataReg[0];
            end
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // pins are open drain, only ever pulled low
  always_ff @(posedge core_clk)
  begin
    sclOut <= 1'b0;
    sdaOut <= 1'b0;
  end

  a_start_code:
  assert property (finStart |=> flag &&
    statusCode == ($past(repeated) ? CODE_RESTART : CODE_START))
    else $error("wrong code after start");

  a_addr_code:
  assert property ((finAck && addrPhase && !readAddr) |=>
    statusCode == ($past(ackLow) ? CODE_ADDR_ACK : CODE_ADDR_NACK) && flag)
    else $error("wrong code after address");

  a_data_code:
  assert property ((finAck && !addrPhase) |=>
    statusCode == ($past(ackLow) ? CODE_DATA_ACK : CODE_DATA_NACK) && flag)
    else $error("wrong code after data byte");

  a_hold_stall:
  assert property ((flag && enable) |->
    state == S_HOLD && (sclOeN == (statusCode == CODE_LOST)))
    else $error("transfer moved while flag set");

  a_wcol_drop:
  assert property ((dataWr && !flag) |=> wcol && dataReg == $past(dataReg))
    else $error("collision write not dropped");

  a_stop_clear:
  assert property ((finStop && !ctrlWr) |=> !stopReq && sdaOeN && sclOeN)
    else $error("stop bit not cleared after stop");

  a_stop_start:
  assert property ((finStop && startReq && !ctrlWr) |=> state == S_WAITFREE)
    else $error("no start after stop");

  a_lost_code:
  assert property (lost |=> statusCode == CODE_LOST && sclOeN && sdaOeN && state == S_HOLD)
    else $error("arbitration loss not reported");

  a_restart_go:
  assert property ((state == S_HOLD && goCmd && flag && statusCode != CODE_LOST &&
    cmdSta && !cmdSto) |=> state == S_RESTART ##1 sdaOeN [*2])
    else $error("no repeated start");

  a_send_byte:
  assert property ((state == S_HOLD && goCmd && flag && statusCode != CODE_LOST &&
    !cmdSta && !cmdSto) |=> state == S_BITS && shift == $past(dataReg) && bitCnt == 3'h0)
    else $error("byte not loaded for sending");

  a_wait_free:
  assert property ((state == S_WAITFREE && busBusy && !ctrlWr) |=> state == S_WAITFREE)
    else $error("start while bus busy");
endmodule : two_wire_master

// ---- bus_slave_model.sv ----
// behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic       sclW,
  input  wire logic       sdaW,
  input  wire logic       ackOn,
  input  wire logic       grab,
  input  wire logic       stretch,
  output logic            sdaPull,
  output logic            sclPull,
  output logic [7:0]      rxByte,
  output int              rxCount,
  output int              startCount,
  output int              stopCount
);
  logic [7:0] sh = 8'h00;
  int         bitCnt = 0;
  logic       ackDrive = 1'h0;
  initial
  begin
    rxByte = 8'h00;
    rxCount = 0;
    startCount = 0;
    stopCount = 0;
  end
  // ack, or a competing master holding data low
  assign sdaPull = ackDrive | grab;
  assign sclPull = stretch;
  always @(negedge sdaW)
    if (sclW === 1'h1)
    begin
      startCount++;
      bitCnt = 0;
    end
  always @(posedge sdaW)
    if (sclW === 1'h1)
      stopCount++;
  // bits taken msb first at clock rise
  always @(posedge sclW)
    if (bitCnt < 8)
    begin
      sh = {sh[6:0], sdaW};
      bitCnt++;
      if (bitCnt == 8)
      begin
        rxByte = sh;
        rxCount++;
      end
    end
    else
      bitCnt = 0;
  always @(negedge sclW)
    ackDrive = (bitCnt == 8) && ackOn;
endmodule : bus_slave_model

// ---- two_wire_master_tb_top.sv ----
// testbench of the two-wire master transmitter
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module two_wire_master_tb_top;
  import two_wire_pkg::*;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        ackOn = 1'h1;
  logic        grab = 1'h0;
  logic        stretch = 1'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic   sclOut, sclOeN, sdaOut, sdaOeN, sdaPull, sclPull, sclW, sdaW;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  rxByte;
  int          rxCount, startCount, stopCount, s0, n, rnd;
  int          seenRx = 0;
  int          fail_count = 0;
  int          check_count = 0;
  int          expQ[$];
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [7:0]  b;

  // open-drain lines with pull-ups
  assign sclW = !((!sclOeN && !sclOut) || sclPull);
  assign sdaW = !((!sdaOeN && !sdaOut) || sdaPull);
  always #10 core_clk = ~core_clk;

  two_wire_master DUT (.core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sclIn(sclW), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .irq(irq));
  bus_slave_model slave (.sclW(sclW), .sdaW(sdaW), .ackOn(ackOn), .grab(grab),
    .stretch(stretch), .sdaPull(sdaPull), .sclPull(sclPull), .rxByte(rxByte),
    .rxCount(rxCount), .startCount(startCount), .stopCount(stopCount));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic tmo;
    fail_count++;
    complete_run();
  endtask : tmo

  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      k++;
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (k > 50)
        tmo();
    end
    while (!bvalid);
    bready <= 1'h0;
    rsp = bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      k++;
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (k > 50)
        tmo();
    end
    while (!rvalid);
    rready <= 1'h0;
    rd = rdata;
    rsp = rresp;
  endtask : axr

  task automatic waitFlag;
    int k;
    k = 0;
    do
    begin
      axr(CTRL_OFS);
      k++;
      if (k > 4000)
        tmo();
    end
    while (rd[FLAG_BIT] !== 1'h1);
  endtask : waitFlag

  task automatic go(input logic [7:0] c, input logic [7:0] code);
    axw(CTRL_OFS, c);
    waitFlag();
    axr(STAT_OFS);
    `CHK(rd[7:0] & CODE_MASK, code)
  endtask : go

  // integer model of the status after a byte
  function automatic logic [7:0] expCode(input int isAddr, input int v, input int ack);
    if (isAddr == 0)
      return (ack != 0) ? CODE_DATA_ACK : CODE_DATA_NACK;
    if (v % 2 == 1)
      return (ack != 0) ? CODE_RADDR_ACK : CODE_RADDR_NACK;
    return (ack != 0) ? CODE_ADDR_ACK : CODE_ADDR_NACK;
  endfunction : expCode

  task automatic send(input logic [7:0] v, input logic ack, input int isAddr);
    axw(DATA_OFS, v);
    ackOn <= ack;
    expQ.push_back(v);
    go(8'h84, expCode(isAddr, v, ack));
  endtask : send

  // every byte seen on the wire against the model queue
  always @(posedge core_clk)
    if (rxCount != seenRx)
    begin
      seenRx = rxCount;
      `CHK(rxByte, 8'(expQ.pop_front()))
    end

  initial
  begin
    rnd = $urandom(32'hC197);
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    axr(STAT_OFS);
    `CHK(rd[7:0], CODE_IDLE)
    axr(8'h40);
    `CHK(rsp, RESP_SLVERR)
    axw(8'h40, 8'hFF);
    `CHK(rsp, RESP_SLVERR)
    axw(IRQ_MASK_OFS, 8'h01);
    go(8'hA4, CODE_START);
    `CHK(irq, 1'h1)
    axw(STAT_OFS, 8'h03);
    axr(STAT_OFS);
    `CHK(rd[1:0], 2'h3)
    axw(IRQ_STAT_OFS, 8'h01);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'h0)
    send(8'hA0, 1'h1, 1);
    repeat (1000) @(posedge core_clk);
    `CHK(sclOeN, 1'h0)
    `CHK(irq, 1'h1)
    axw(IRQ_MASK_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'h0)
    axw(IRQ_STAT_OFS, 8'h07);
    send(8'($urandom), 1'h1, 0);
    b = 8'($urandom);
    axw(DATA_OFS, b);
    ackOn <= 1'h0;
    expQ.push_back(b);
    axw(CTRL_OFS, 8'h84);
    axw(DATA_OFS, 8'h5A);
    axr(CTRL_OFS);
    `CHK(rd[WCOL_BIT], 1'h1)
    axr(IRQ_STAT_OFS);
    `CHK(rd[IRQ_WCOL], 1'h1)
    for (n = 0; n < 300 && sclW !== 1'h0; n++)
      @(posedge core_clk);
    if (sclW !== 1'h0)
      tmo();
    stretch <= 1'h1;
    repeat (3000) @(posedge core_clk);
    stretch <= 1'h0;
    waitFlag();
    axr(STAT_OFS);
    `CHK(rd[7:0] & CODE_MASK, CODE_DATA_NACK)
    go(8'hA4, CODE_RESTART);
    send(8'hA2, 1'h0, 1);
    s0 = stopCount;
    go(8'hB4, CODE_START);
    `CHK(stopCount, s0 + 1)
    axr(CTRL_OFS);
    `CHK(rd[STOP_BIT], 1'h0)
    send(8'hA0, 1'h1, 1);
    send(8'($urandom), 1'h1, 0);
    go(8'hA4, CODE_RESTART);
    send(8'hA1, 1'h0, 1);
    go(8'hA4, CODE_RESTART);
    send(8'hA3, 1'h1, 1);
    s0 = stopCount;
    axw(CTRL_OFS, 8'h94);
    n = 0;
    do
    begin
      axr(CTRL_OFS);
      n++;
      if (n > 1000)
        tmo();
    end
    while (rd[STOP_BIT] !== 1'h0);
    repeat (500) @(posedge core_clk);
    `CHK(stopCount, s0 + 1)
    `CHK(rd[FLAG_BIT], 1'h0)
    go(8'hA4, CODE_START);
    grab <= 1'h1;
    axw(DATA_OFS, 8'hFF);
    go(8'h84, CODE_LOST);
    axw(CTRL_OFS, 8'hA4);
    repeat (2000) @(posedge core_clk);
    axr(CTRL_OFS);
    `CHK(rd[FLAG_BIT], 1'h0)
    s0 = startCount;
    grab <= 1'h0;
    waitFlag();
    axr(STAT_OFS);
    `CHK(rd[7:0] & CODE_MASK, CODE_START)
    `CHK(startCount, s0 + 1)
    grab <= 1'h1;
    axw(DATA_OFS, 8'hFF);
    go(8'h84, CODE_LOST);
    axw(CTRL_OFS, 8'h84);
    repeat (10) @(posedge core_clk);
    `CHK(sclOeN, 1'h1)
    `CHK(sdaOeN, 1'h1)
    grab <= 1'h0;
    repeat (10) @(posedge core_clk);
    complete_run();
  end
endmodule : two_wire_master_tb_top
